// [hdl/btcs_branch_unit.sv]
// Branch target builder, condition test and condition bit logic
// Operation
// - Jump displacement is 24-bit long offset with two zero bits below, signed 26-bit.
// - Conditional displacement is 14-bit short offset with two zeros below, signed 16-bit.
// - Absolute flag clear: target is current address plus signed displacement.
// - Relative addition wraps modulo two to the thirty-second.
// - Absolute flag set: target is the sign-extended displacement alone.
// - Indirect conditional jumps take target from return or count register.
// - Five-bit test index selects one condition bit, 0 to 31.
// - Top option bit one: condition register ignored in the decision.
// - Unconditional jump always taken; index positions belong to long offset.
// - Condition logic combines two selected bits by eight functions into third.
// - Top option bit zero: selected bit must equal second option bit.
// - Third option bit zero: decrement count, test zero or nonzero by fourth.
// - Save-return flag set: return register loads jump address plus 4.
// - Return register as target has its two low bits ignored.
module btcs_branch_unit
   import btcs_pkg::*;
(
   input  wire logic        clock_i,
   input  wire logic        rst_i,
   input  wire btcs_req_s   instr_i,
   input  wire btcs_load_s  load_i,
   output btcs_redir_s      redir_o,
   output logic [0:31]      condition_register_o,
   output logic [31:0]      return_addr_reg_o,
   output logic [31:0]      loop_count_reg_o
);

   // Architectural state, bit 0 of the condition register is its most significant bit
   logic [0:31]        condition_register;
   logic [31:0]        return_addr_reg;
   logic [31:0]        loop_count_reg;
   btcs_redir_s        redir;

   // Field extraction
   wire logic [31:0]   word               = instr_i.word;
   wire logic [31:0]   current_instr_addr = instr_i.addr;
   wire logic [5:0]    opcode             = word[BTCS_OP_LSB +: 6];
   wire logic [9:0]    xo                 = word[BTCS_XO_LSB +: 10];
   wire logic [23:0]   long_offset_field  = word[BTCS_LONG_LSB +: BTCS_LONG_W];
   wire logic [13:0]   short_offset_field = word[BTCS_SHORT_LSB +: BTCS_SHORT_W];
   wire logic          absolute_form_flag = word[BTCS_ABS_BIT];
   wire logic          save_return_flag   = word[BTCS_SAVE_BIT];
   wire logic [0:4]    branch_options     = word[BTCS_OPT_LSB +: 5];
   wire logic [4:0]    test_flag_index    = word[BTCS_IDX_A_LSB +: 5];
   wire logic [4:0]    src_b_index        = word[BTCS_IDX_B_LSB +: 5];
   wire logic [4:0]    dst_index          = word[BTCS_OPT_LSB +: 5];

   // Instruction class decode
   wire logic          is_jump     = instr_i.valid && (opcode == BTCS_OP_JUMP);
   wire logic          is_cjump    = instr_i.valid && (opcode == BTCS_OP_CJUMP);
   wire logic          is_ext      = instr_i.valid && (opcode == BTCS_OP_EXT);
   wire logic          is_to_ret   = is_ext && (xo == BTCS_XO_TO_RET);
   wire logic          is_to_cnt   = is_ext && (xo == BTCS_XO_TO_CNT);
   wire logic          is_cond     = is_cjump || is_to_ret || is_to_cnt;
   wire logic          is_branch   = is_jump || is_cond;
   wire logic          is_cr_and   = is_ext && (xo == BTCS_XO_CAND);
   wire logic          is_cr_andc  = is_ext && (xo == BTCS_XO_CANDC);
   wire logic          is_cr_eqv   = is_ext && (xo == BTCS_XO_CEQV);
   wire logic          is_cr_nand  = is_ext && (xo == BTCS_XO_CNAND);
   wire logic          is_cr_nor   = is_ext && (xo == BTCS_XO_CNOR);
   wire logic          is_cr_or    = is_ext && (xo == BTCS_XO_COR);
   wire logic          is_cr_orc   = is_ext && (xo == BTCS_XO_CORC);
   wire logic          is_cr_xor   = is_ext && (xo == BTCS_XO_CXOR);
   wire logic          is_cr_logic = is_cr_and || is_cr_andc || is_cr_eqv || is_cr_nand
                                     || is_cr_nor || is_cr_or || is_cr_orc || is_cr_xor;

   wire logic [25:0]   long_disp   = {long_offset_field, 2'b00};
   wire logic [15:0]   short_disp  = {short_offset_field, 2'b00};
   wire logic [31:0]   long_ext    = {{6{long_disp[25]}}, long_disp};
   wire logic [31:0]   short_ext   = {{16{short_disp[15]}}, short_disp};
   wire logic [31:0]   disp_ext    = is_jump ? long_ext : short_ext;
   // relative sum wraps in 32 bits
   wire logic [31:0]   rel_target  = current_instr_addr + disp_ext;
   wire logic [31:0]   imm_target  = absolute_form_flag ? disp_ext : rel_target;
   wire logic [31:0]   ret_target  = return_addr_reg & BTCS_ALIGN_MASK;
   wire logic [31:0]   next_target = is_to_ret ? ret_target
                                     : is_to_cnt ? loop_count_reg : imm_target;

   wire logic          tested_bit  = condition_register[test_flag_index];
   wire logic          cr_ok       = branch_options[0] || (tested_bit == branch_options[1]);
   wire logic          cnt_dec     = is_cond && !branch_options[2];
   wire logic [31:0]   next_count  = loop_count_reg - 32'h0000_0001;
   wire logic          cnt_zero    = (next_count == 32'h0000_0000);
   wire logic          cnt_ok      = branch_options[2] || (cnt_zero == branch_options[3]);
   // unconditional jump ignores options and index positions
   wire logic          next_taken  = is_jump || (is_cond && cr_ok && cnt_ok);

   wire logic          bit_a       = condition_register[test_flag_index];
   wire logic          bit_b       = condition_register[src_b_index];
   wire logic          next_crbit  = is_cr_and  ? (bit_a & bit_b)
                                   : is_cr_andc ? (bit_a & ~bit_b)
                                   : is_cr_eqv  ? ~(bit_a ^ bit_b)
                                   : is_cr_nand ? ~(bit_a & bit_b)
                                   : is_cr_nor  ? ~(bit_a | bit_b)
                                   : is_cr_or   ? (bit_a | bit_b)
                                   : is_cr_orc  ? (bit_a | ~bit_b)
                                   :              (bit_a ^ bit_b);

   wire logic          ret_save    = is_branch && save_return_flag;
   wire logic [31:0]   next_ret    = current_instr_addr + BTCS_RET_STEP;

   // Register moves from decode yield to an instruction in the same cycle
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         condition_register <= BTCS_CR_RST;
      end else if (is_cr_logic) begin
         condition_register[dst_index] <= next_crbit;
      end else if (load_i.cr_we) begin
         condition_register <= load_i.data;
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         return_addr_reg <= BTCS_RET_RST;
      end else if (ret_save) begin
         return_addr_reg <= next_ret;
      end else if (load_i.ret_we) begin
         return_addr_reg <= load_i.data;
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         loop_count_reg <= BTCS_CNT_RST;
      end else if (cnt_dec) begin
         loop_count_reg <= next_count;
      end else if (load_i.cnt_we) begin
         loop_count_reg <= load_i.data;
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         redir <= '{done: 1'b0, is_jump: 1'b0, taken: 1'b0, target: BTCS_TGT_RST};
      end else begin
         redir.done    <= is_branch || is_cr_logic;
         redir.is_jump <= is_branch;
         redir.taken   <= next_taken;
         redir.target  <= is_branch ? next_target : BTCS_TGT_RST;
      end
   end

   assign redir_o              = redir;
   assign condition_register_o = condition_register;
   assign return_addr_reg_o    = return_addr_reg;
   assign loop_count_reg_o     = loop_count_reg;

   // Checks
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);

   sequence s_rel_jump;
      is_jump && !absolute_form_flag;
   endsequence

   a_rel_long_target: assert property (
      s_rel_jump |=> redir.target == $past(current_instr_addr)
                     + {{6{$past(word[25])}}, $past(word[25:2]), 2'b00})
      else $error("relative long jump target wrong");

   a_short_abs_target: assert property (
      (is_cjump && absolute_form_flag) |=>
         redir.target == {{16{$past(word[15])}}, $past(word[15:2]), 2'b00})
      else $error("absolute short target wrong");

   a_rel_short_target: assert property (
      (is_cjump && !absolute_form_flag) |=>
         (redir.target - $past(current_instr_addr)) ==
         {{16{$past(word[15])}}, $past(word[15:2]), 2'b00})
      else $error("relative short target wrong");

   a_wrap_around: assert property (
      (s_rel_jump and (current_instr_addr == 32'hFFFF_FFFC && word[25:2] == 24'h000001))
      |=> redir.target == 32'h0000_0000)
      else $error("relative target does not wrap");

   a_abs_ignores_addr: assert property (
      (is_jump && absolute_form_flag) |=>
         redir.target == {{6{$past(word[25])}}, $past(word[25:2]), 2'b00})
      else $error("absolute jump target wrong");

   a_cnt_target: assert property (
      is_to_cnt |=> redir.target == $past(loop_count_reg))
      else $error("count register target wrong");

   a_cr_test_taken: assert property (
      (is_cjump && !word[25] && word[23]) |=>
         redir.taken == ($past(condition_register[word[20:16]]) == $past(word[24]))
      ) else $error("condition test outcome wrong");

   a_cr_ignored: assert property (
      (is_cond && word[25] && word[23]) |=> redir.taken)
      else $error("ignored condition still affects decision");

   a_jump_always: assert property (
      is_jump |=> redir.taken && redir.done && redir.is_jump)
      else $error("unconditional jump not taken");

   a_cnt_decrement: assert property (
      (is_cond && !word[23] && !load_i.cnt_we) |=>
         loop_count_reg == $past(loop_count_reg) - 32'h0000_0001
         && redir.taken == ($past(word[22]) == (loop_count_reg == 32'h0000_0000)
            && ($past(word[25]) || $past(condition_register[word[20:16]]) == $past(word[24]))))
      else $error("count decrement or test wrong");

   a_ret_save: assert property (
      (is_branch && save_return_flag) |=>
         return_addr_reg == $past(current_instr_addr) + 32'h0000_0004)
      else $error("return address not saved");

   a_ret_aligned: assert property (
      is_to_ret |=> redir.target[1:0] == 2'b00
                    && redir.target[31:2] == $past(return_addr_reg[31:2]))
      else $error("return target not aligned");

   a_cr_xor_logic: assert property (
      is_cr_xor |=> condition_register[$past(dst_index)] ==
         ($past(condition_register[word[20:16]]) ^ $past(condition_register[word[15:11]])))
      else $error("condition logic result wrong");

   a_target_aligned: assert property (
      (redir.is_jump && !$past(is_to_cnt)) |-> redir.target[1:0] == 2'b00)
      else $error("computed target not word aligned");

   a_index_select: assert property (
      (is_cjump && word[23] && !word[25]) |=>
         redir.taken != ($past(condition_register[word[20:16]]) != $past(word[24])))
      else $error("tested bit not the indexed one");

endmodule // btcs_branch_unit

// [include/btcs_pkg.sv]
// Constants and carrier types for the branch target and condition select block
package btcs_pkg;
   localparam int          BTCS_XLEN        = 32;
   // Primary and extended operation codes
   localparam logic [5:0]  BTCS_OP_JUMP     = 6'h12;
   localparam logic [5:0]  BTCS_OP_CJUMP    = 6'h10;
   localparam logic [5:0]  BTCS_OP_EXT      = 6'h13;
   localparam logic [9:0]  BTCS_XO_TO_RET   = 10'h010;
   localparam logic [9:0]  BTCS_XO_TO_CNT   = 10'h210;
   localparam logic [9:0]  BTCS_XO_CAND     = 10'h101;
   localparam logic [9:0]  BTCS_XO_CANDC    = 10'h081;
   localparam logic [9:0]  BTCS_XO_CEQV     = 10'h121;
   localparam logic [9:0]  BTCS_XO_CNAND    = 10'h0E1;
   localparam logic [9:0]  BTCS_XO_CNOR     = 10'h021;
   localparam logic [9:0]  BTCS_XO_COR      = 10'h1C1;
   localparam logic [9:0]  BTCS_XO_CORC     = 10'h1A1;
   localparam logic [9:0]  BTCS_XO_CXOR     = 10'h0C1;
   // Field positions (bit 0 is the least significant bit of the word)
   localparam int          BTCS_OP_LSB      = 26;
   localparam int          BTCS_LONG_LSB    = 2;
   localparam int          BTCS_LONG_W      = 24;
   localparam int          BTCS_SHORT_LSB   = 2;
   localparam int          BTCS_SHORT_W     = 14;
   localparam int          BTCS_OPT_LSB     = 21;
   localparam int          BTCS_IDX_A_LSB   = 16;
   localparam int          BTCS_IDX_B_LSB   = 11;
   localparam int          BTCS_XO_LSB      = 1;
   localparam int          BTCS_ABS_BIT     = 1;
   localparam int          BTCS_SAVE_BIT    = 0;
   // Step to the instruction after a jump
   localparam logic [31:0] BTCS_RET_STEP    = 32'h0000_0004;
   localparam logic [31:0] BTCS_ALIGN_MASK  = 32'hFFFF_FFFC;
   // Reset values
   localparam logic [31:0] BTCS_CR_RST      = 32'h0000_0000;
   localparam logic [31:0] BTCS_RET_RST     = 32'h0000_0000;
   localparam logic [31:0] BTCS_CNT_RST     = 32'h0000_0000;
   localparam logic [31:0] BTCS_TGT_RST     = 32'h0000_0000;

   // Decoded instruction from the decode stage
   typedef struct packed {
      logic        valid;
      logic [31:0] word;
      logic [31:0] addr;
   } btcs_req_s;

   // Direct loads of the three branch registers from register moves
   typedef struct packed {
      logic        cr_we;
      logic        ret_we;
      logic        cnt_we;
      logic [31:0] data;
   } btcs_load_s;

   // Answer towards the fetch redirect logic
   typedef struct packed {
      logic        done;
      logic        is_jump;
      logic        taken;
      logic [31:0] target;
   } btcs_redir_s;
endpackage : btcs_pkg

// [tb/btcs_decode_model.sv]
// Decode stage model that presents instructions and register moves
module btcs_decode_model
   import btcs_pkg::*;
(
   input  wire logic  clock_i,
   output btcs_req_s  instr_o,
   output btcs_load_s load_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      instr_o = '0;
      load_o  = '0;
   end
   // Held for one edge; afterwards valid and write enables drop and word, addr and data show the inverse, never a stale copy
   task automatic issue(input logic [31:0] word, input logic [31:0] addr);
      @(negedge clock_i);
      instr_o = '{valid: 1'b1, word: word, addr: addr};
      @(negedge clock_i);
      instr_o = '{valid: 1'b0, word: ~word, addr: ~addr};
   endtask
   task automatic move(input logic [2:0] we, input logic [31:0] data);
      @(negedge clock_i);
      load_o = '{cr_we: we[2], ret_we: we[1], cnt_we: we[0], data: data};
      @(negedge clock_i);
      load_o = '{cr_we: 1'b0, ret_we: 1'b0, cnt_we: 1'b0, data: ~data};
   endtask
endmodule // btcs_decode_model

// [tb/branch_target_and_cond_select_bench.sv]
// Self-checking bench for the branch target and condition select block
module branch_target_and_cond_select_bench
   import btcs_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   logic        clock = 1'b0;
   logic        rst   = 1'b1;
   btcs_req_s   instr;
   btcs_load_s  load;
   btcs_redir_s redir;
   logic [0:31] cr;
   logic [31:0] ret;
   logic [31:0] cnt;
   int          n_fail = 0;
   int          samples_checked = 0;
   int          cycles = 0;
   always #4 clock = ~clock;
   btcs_decode_model i_btcs_decode_model (.clock_i(clock), .instr_o(instr), .load_o(load));
   btcs_branch_unit i_btcs_branch_unit (.clock_i(clock), .rst_i(rst), .instr_i(instr),
      .load_i(load), .redir_o(redir), .condition_register_o(cr),
      .return_addr_reg_o(ret), .loop_count_reg_o(cnt));
   task automatic cmp32(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cmp1(input string what, input logic exp, input logic got);
      cmp32(what, {31'h0, exp}, {31'h0, got});
   endtask
   task automatic end_of_test();
      $display("checked %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   function automatic logic [31:0] jw(logic [23:0] li, logic aa, logic lk);
      return {BTCS_OP_JUMP, li, aa, lk};
   endfunction
   function automatic logic [31:0] cw(logic [4:0] bo, logic [4:0] bi, logic [13:0] bd, logic aa);
      return {BTCS_OP_CJUMP, bo, bi, bd, aa, 1'b0};
   endfunction
   function automatic logic [31:0] xw(logic [4:0] d, logic [4:0] a, logic [4:0] b, logic [9:0] xo,
                                      logic lk);
      return {BTCS_OP_EXT, d, a, b, xo, lk};
   endfunction
   task automatic br(input logic [31:0] w, input logic [31:0] a, input logic tk,
                     input logic [31:0] tgt);
      i_btcs_decode_model.issue(w, a);
      cmp1("done", 1'b1, redir.done);
      cmp1("is_jump", 1'b1, redir.is_jump);
      cmp1("taken", tk, redir.taken);
      if (tk) cmp32("target", tgt, redir.target);
   endtask
   task automatic t_reset();
      cmp32("cr", 32'h0000_0000, cr);
      cmp32("ret", 32'h0000_0000, ret);
      cmp32("cnt", 32'h0000_0000, cnt);
      cmp1("done", 1'b0, redir.done);
      $display("test reset ends");
   endtask
   task automatic t_jump();
      br(jw(24'h000010, 1'b0, 1'b1), 32'h0000_1000, 1'b1, 32'h0000_1040);
      cmp32("ret", 32'h0000_1004, ret);
      br(jw(24'h000008, 1'b0, 1'b0), 32'hFFFF_FFF0, 1'b1, 32'h0000_0010);
      br(jw(24'h000001, 1'b0, 1'b0), 32'hFFFF_FFFC, 1'b1, 32'h0000_0000);
      br(jw(24'hFFFFFC, 1'b0, 1'b0), 32'h0000_0008, 1'b1, 32'hFFFF_FFF8);
      br(jw(24'h800000, 1'b1, 1'b0), 32'h0000_5000, 1'b1, 32'hFE00_0000);
      cmp32("ret", 32'h0000_1004, ret);
      br(cw(5'b10100, 5'h1F, 14'h3FFF, 1'b0), 32'h0000_0100, 1'b1, 32'h0000_00FC);
      br(cw(5'b10100, 5'h00, 14'h2000, 1'b1), 32'h0000_0100, 1'b1, 32'hFFFF_8000);
      $display("test jump ends");
   endtask
   task automatic t_cr_test();
      logic [4:0] bo [6] = '{5'b01100, 5'b01100, 5'b01100, 5'b00100, 5'b00100, 5'b11100};
      logic [4:0] bi [6] = '{5'd0, 5'd1, 5'd31, 5'd1, 5'd31, 5'd1};
      logic       tk [6] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
      i_btcs_decode_model.move(3'b100, 32'h8000_0001);
      for (int k = 0; k < 6; k++) begin
         br(cw(bo[k], bi[k], 14'h0010, 1'b0), 32'h0000_0400, tk[k], 32'h0000_0440);
      end
      $display("test condition ends");
   endtask
   task automatic t_count();
      i_btcs_decode_model.move(3'b001, 32'h0000_0002);
      br(cw(5'b10000, 5'd0, 14'h0004, 1'b0), 32'h0000_0800, 1'b1, 32'h0000_0810);
      cmp32("cnt", 32'h0000_0001, cnt);
      br(cw(5'b10000, 5'd0, 14'h0004, 1'b0), 32'h0000_0800, 1'b0, 32'h0);
      i_btcs_decode_model.move(3'b001, 32'h0000_0001);
      br(cw(5'b10010, 5'd0, 14'h0004, 1'b0), 32'h0000_0800, 1'b1, 32'h0000_0810);
      cmp32("cnt", 32'h0000_0000, cnt);
      $display("test count ends");
   endtask
   task automatic t_indirect();
      i_btcs_decode_model.move(3'b010, 32'h1234_5677);
      br(xw(5'b10100, 5'd0, 5'd0, BTCS_XO_TO_RET, 1'b1), 32'h200, 1'b1,
         32'h1234_5674);
      cmp32("ret", 32'h0000_0204, ret);
      i_btcs_decode_model.move(3'b001, 32'h0000_4000);
      br(xw(5'b10100, 5'd0, 5'd0, BTCS_XO_TO_CNT, 1'b0), 32'h200, 1'b1, 32'h0000_4000);
      $display("test indirect ends");
   endtask
   task automatic t_cr_logic();
      logic [9:0] xo [8] = '{BTCS_XO_CAND, BTCS_XO_CANDC, BTCS_XO_CEQV, BTCS_XO_CNAND,
                             BTCS_XO_CNOR, BTCS_XO_COR, BTCS_XO_CORC, BTCS_XO_CXOR};
      logic [4:0] sa [4] = '{5'd2, 5'd3, 5'd4, 5'd6};
      logic [4:0] sb [4] = '{5'd3, 5'd2, 5'd5, 5'd7};
      logic       a;
      logic       b;
      logic       r;
      for (int k = 0; k < 8; k++) begin
         for (int p = 0; p < 4; p++) begin
            i_btcs_decode_model.move(3'b100, 32'h2C00_0000);
            a = (p == 0 || p == 2);
            b = (p == 1 || p == 2);
            case (k)
               0: r = a & b;
               1: r = a & ~b;
               2: r = ~(a ^ b);
               3: r = ~(a & b);
               4: r = ~(a | b);
               5: r = a | b;
               6: r = a | ~b;
               default: r = a ^ b;
            endcase
            i_btcs_decode_model.issue(xw(5'd20, sa[p], sb[p], xo[k], 1'b0), 32'h0000_0600);
            cmp1("logic done", 1'b1, redir.done);
            cmp1("logic is_jump", 1'b0, redir.is_jump);
            cmp32("cr", 32'h2C00_0000 | {20'h0, r, 11'h0}, cr);
         end
      end
      $display("test condition logic ends");
   endtask
   task automatic t_refused();
      i_btcs_decode_model.issue({6'h3F, 26'h0000001}, 32'h0000_0700);
      cmp1("done", 1'b0, redir.done);
      cmp32("ret", 32'h0000_0204, ret);
      fork
         i_btcs_decode_model.issue(jw(24'h000001, 1'b0, 1'b1), 32'h0000_0300);
         i_btcs_decode_model.move(3'b010, 32'hAAAA_AAA8);
      join
      cmp32("ret", 32'h0000_0304, ret);
      $display("test refused ends");
   endtask
   always @(posedge clock) begin
      cycles++;
      if (cycles == 3000) begin
         n_fail++;
         end_of_test();
      end
   end
   initial begin
      repeat (5) @(posedge clock);
      @(negedge clock);
      rst = 1'b0;
      t_reset();
      t_jump();
      t_cr_test();
      t_count();
      t_indirect();
      t_cr_logic();
      t_refused();
      end_of_test();
   end
endmodule // branch_target_and_cond_select_bench
